// file: verilog/led_dimming_params.svh
// What this block does
// - DC level at 0x07 scales channel peak current
// - DC level 0..255, resets to 0xff
// - Reset DC level gives full resistor current
// - DC level writes apply at once, no restart
// - DC level zero disconnects all six channels
// - Internal mode: 255-step duty from brightness
// - Ratio mode: internal frequency, product duty
// - Ratio mode selected after reset
// - Selected PWM chops all six channels together
// - Shut down about 30 ms after enable low
// - Mode at 0x01: 0x05, 0x03, 0x01
// - Brightness at 0x00, reset 0xff, zero off
`ifndef LED_DIMMING_PARAMS_SVH
`define LED_DIMMING_PARAMS_SVH

`define OFS_BRIGHTNESS 8'h00
`define OFS_MODE 8'h01
`define OFS_DC_LEVEL 8'h07

`define RST_BRIGHTNESS 8'hff
`define RST_MODE 8'h01
`define RST_DC_LEVEL 8'hff

`define MODE_INTERNAL 8'h05
`define MODE_EXTERNAL 8'h03
`define MODE_RATIO 8'h01

`define DUTY_FULL 8'hff
`define PWM_STEP_LAST 8'hfe

`define CLK_FREQ_HZ 40000000
`define SHDN_TIME_MS 30
`define SHDN_CYCLES (`SHDN_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define PWM_PRESCALE 784
`define MEAS_CNT_W 18

`endif

// file: verilog/led_dimming_pkg.sv
package led_dimming_pkg;
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_DIV = 2'b10
  } meas_state_e;
  typedef logic [7:0] duty_t;
endpackage

// file: verilog/pwm_meas_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pwm_meas_if;
  logic level;
  led_dimming_pkg::duty_t duty;
  modport meas(input level, output duty);
  modport user(output level, input duty);
endinterface
`default_nettype wire

// file: verilog/pwm_duty_meas.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_dimming_params.svh"
module pwm_duty_meas #(
  parameter int CNT_W = `MEAS_CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  pwm_meas_if.meas m
);
  localparam int NUM_W = CNT_W + 8;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  led_dimming_pkg::meas_state_e state_q, state_d;
  logic prev_q, prev_d;
  logic [CNT_W-1:0] per_q, per_d, hi_q, hi_d, den_q, den_d;
  logic [NUM_W-1:0] rem_q, rem_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] quot_q, quot_d, duty_q, duty_d;
  logic rise;
  logic [NUM_W-1:0] trial;

  assign rise = m.level & ~prev_q;
  assign m.duty = duty_q;

  // Period and high time, restoring divide high*255/period
  always_comb begin
    state_d = state_q;
    prev_d = m.level;
    per_d = per_q;
    hi_d = hi_q;
    den_d = den_q;
    rem_d = rem_q;
    bit_d = bit_q;
    quot_d = quot_q;
    duty_d = duty_q;
    trial = NUM_W'({8'h00, den_q} << bit_q);
    if (rise) begin
      per_d = CNT_W'(1);
      hi_d = CNT_W'(1);
    end else begin
      if (per_q != CNT_MAX) begin
        per_d = per_q + CNT_W'(1);
      end
      if (m.level && hi_q != CNT_MAX) begin
        hi_d = hi_q + CNT_W'(1);
      end
    end
    case (state_q)
      led_dimming_pkg::MEAS_IDLE: begin
        if (rise) begin
          den_d = per_q;
          rem_d = NUM_W'({hi_q, 8'h00} - {8'h00, hi_q});
          bit_d = 3'h7;
          quot_d = 8'h00;
          state_d = led_dimming_pkg::MEAS_DIV;
        end else if (per_q == CNT_MAX) begin
          duty_d = m.level ? `DUTY_FULL : 8'h00;
        end
      end
      led_dimming_pkg::MEAS_DIV: begin
        if (rem_q >= trial) begin
          rem_d = rem_q - trial;
          quot_d[bit_q] = 1'b1;
        end
        if (bit_q == 3'h0) begin
          duty_d = (rem_q >= trial) ? (quot_q | 8'h01) : quot_q;
          state_d = led_dimming_pkg::MEAS_IDLE;
        end else begin
          bit_d = bit_q - 3'h1;
        end
      end
      default: state_d = led_dimming_pkg::MEAS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= led_dimming_pkg::MEAS_IDLE;
      prev_q <= 1'b0;
      per_q <= '0;
      hi_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      bit_q <= 3'h0;
      quot_q <= 8'h00;
      duty_q <= 8'h00;
    end else begin
      state_q <= state_d;
      prev_q <= prev_d;
      per_q <= per_d;
      hi_q <= hi_d;
      den_q <= den_d;
      rem_q <= rem_d;
      bit_q <= bit_d;
      quot_q <= quot_d;
      duty_q <= duty_d;
    end
  end
endmodule
`default_nettype wire

// file: verilog/led_dimming_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_dimming_params.svh"
module led_dimming_control #(
  parameter int SHDN_CYCLES = `SHDN_CYCLES,
  parameter int PWM_PRESCALE = `PWM_PRESCALE,
  parameter int MEAS_CNT_W = `MEAS_CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic external_pwm_duty,
  input wire logic enable_pin,
  output logic [5:0] channel_on,
  output logic [7:0] dc_current_level,
  output logic active
);
  localparam int PRE_W = $clog2(PWM_PRESCALE + 1);
  localparam int SHDN_W = $clog2(SHDN_CYCLES + 1);

  function automatic logic [7:0] div255(input logic [15:0] p);
    logic [16:0] s;
    s = 17'(p) + 17'(p[15:8]) + 17'h00001;
    return s[15:8];
  endfunction

  function automatic logic on_phase(input logic [7:0] step,
    input logic [7:0] duty);
    return step < duty;
  endfunction

  // Register file
  logic [7:0] bright_q, bright_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] dc_q, dc_d;
  // Read data
  logic [7:0] rdata_q, rdata_d;
  // Internal period counter
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [7:0] step_q, step_d;
  // Enable shutdown timer
  logic [SHDN_W-1:0] shdn_q, shdn_d;
  logic active_q, active_d;
  // Channel drive
  logic [5:0] chan_q, chan_d;
  // Pin synchronisers
  logic pwm_s1_q, pwm_s2_q;
  logic pwm_s1_d, pwm_s2_d;
  logic en_s1_q, en_s2_q;
  logic en_s1_d, en_s2_d;
  // Selected source
  logic [7:0] duty_eff;
  logic chop;

  pwm_meas_if meas_bus();
  assign meas_bus.level = pwm_s2_q;

  pwm_duty_meas #(.CNT_W(MEAS_CNT_W)) u_meas (
    .clk(clk),
    .nrst(nrst),
    .m(meas_bus)
  );

  assign reg_rdata = rdata_q;
  assign dc_current_level = dc_q;
  assign channel_on = chan_q;
  assign active = active_q;

  // Registers
  always_comb begin
    bright_d = bright_q;
    mode_d = mode_q;
    dc_d = dc_q;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_BRIGHTNESS: bright_d = reg_wdata;
        `OFS_MODE: mode_d = reg_wdata;
        `OFS_DC_LEVEL: dc_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bright_q <= `RST_BRIGHTNESS;
      mode_q <= `RST_MODE;
      dc_q <= `RST_DC_LEVEL;
    end else begin
      bright_q <= bright_d;
      mode_q <= mode_d;
      dc_q <= dc_d;
    end
  end

  // Read data, held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_BRIGHTNESS: rdata_d = bright_q;
        `OFS_MODE: rdata_d = mode_q;
        `OFS_DC_LEVEL: rdata_d = dc_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Source selection and effective duty
  always_comb begin
    case (mode_q)
      `MODE_INTERNAL: begin
        duty_eff = bright_q;
        chop = on_phase(step_q, duty_eff);
      end
      `MODE_EXTERNAL: begin
        duty_eff = meas_bus.duty;
        chop = pwm_s2_q;
      end
      default: begin
        duty_eff = div255(16'(bright_q) * 16'(meas_bus.duty));
        chop = on_phase(step_q, duty_eff);
      end
    endcase
  end

  // Internal period counter
  always_comb begin
    pre_d = pre_q;
    step_d = step_q;
    if (pre_q == PRE_W'(PWM_PRESCALE - 1)) begin
      pre_d = '0;
      step_d = (step_q == `PWM_STEP_LAST) ? 8'h00 : step_q + 8'h01;
    end else begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
      step_q <= 8'h00;
    end else begin
      pre_q <= pre_d;
      step_q <= step_d;
    end
  end

  // Enable shutdown timer
  always_comb begin
    shdn_d = shdn_q;
    active_d = active_q;
    if (en_s2_q) begin
      shdn_d = '0;
      active_d = 1'b1;
    end else if (active_q) begin
      if (shdn_q == SHDN_W'(SHDN_CYCLES - 1)) begin
        active_d = 1'b0;
      end else begin
        shdn_d = shdn_q + SHDN_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shdn_q <= '0;
      active_q <= 1'b0;
    end else begin
      shdn_q <= shdn_d;
      active_q <= active_d;
    end
  end

  // Channel drive
  always_comb begin
    if (active_q && chop && dc_q != 8'h00 && bright_q != 8'h00) begin
      chan_d = 6'h3f;
    end else begin
      chan_d = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_q <= 6'h00;
    end else begin
      chan_q <= chan_d;
    end
  end

  // Pin synchronisers, two flops each
  always_comb begin
    pwm_s1_d = external_pwm_duty;
    pwm_s2_d = pwm_s1_q;
    en_s1_d = enable_pin;
    en_s2_d = en_s1_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_s1_q <= 1'b0;
      pwm_s2_q <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      pwm_s1_q <= pwm_s1_d;
      pwm_s2_q <= pwm_s2_d;
      en_s1_q <= en_s1_d;
      en_s2_q <= en_s2_d;
    end
  end
endmodule
`default_nettype wire

// file: test/led_dimming_properties.sv
`timescale 1ns/100ps
`default_nettype none
module led_dimming_properties #(
  parameter int SHDN_CYCLES = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic external_pwm_duty,
  input wire logic enable_pin,
  input wire logic [5:0] channel_on,
  input wire logic [7:0] dc_current_level,
  input wire logic active
);
  int low_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_q <= 0;
    end else begin
      low_q <= enable_pin ? 0 : low_q + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence dc_zero; dc_current_level == 8'h00 [*2]; endsequence
  sequence idle; !active [*2]; endsequence
  a_dc_write: assert property (reg_wr && reg_addr == 8'h07 |=>
    dc_current_level == $past(reg_wdata)) else $error("dc level stale");
  a_dc_zero_off: assert property (dc_zero |-> channel_on == 6'h00)
    else $error("channels on at zero dc level");
  a_channels_equal: assert property (
    channel_on inside {6'h00, 6'h3f}) else $error("channels differ");
  a_idle_no_drive: assert property (idle |-> channel_on == 6'h00)
    else $error("channels on while shut down");
  a_active_late: assert property ($fell(active) |->
    low_q >= SHDN_CYCLES && low_q <= SHDN_CYCLES + 6) else $error("bad stop");
  a_active_rise: assert property ($rose(active) |->
    $past(enable_pin, 3)) else $error("active rose without enable");
  a_rd_unmapped: assert property (reg_rd && reg_addr > 8'h07 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_rd_dc_level: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h07 |=> reg_rdata == dc_current_level)
    else $error("dc readback wrong");
endmodule
bind led_dimming_control led_dimming_properties #(
  .SHDN_CYCLES(SHDN_CYCLES)) props_i (.clk(clk), .nrst(nrst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .active(active),
  .external_pwm_duty(external_pwm_duty), .enable_pin(enable_pin),
  .channel_on(channel_on), .dc_current_level(dc_current_level));
`default_nettype wire

// file: test/ext_pwm_source.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pwm_source (
  input wire logic clk,
  input wire logic [3:0] high_cnt,
  output logic pwm
);
  logic [3:0] cnt_q = 4'h0;
  always @(negedge clk) cnt_q <= cnt_q + 4'h1;
  assign pwm = cnt_q < high_cnt;
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dc_level;
  logic enable_pin = 1'b1, ext_pwm, active;
  logic [5:0] channel_on;
  logic [3:0] high_cnt = 4'h8;
  int errors = 0, total_checks = 0, cycles = 0;
  ext_pwm_source ext_pwm_source_i (.clk(clk), .high_cnt(high_cnt),
    .pwm(ext_pwm));
  led_dimming_control #(.SHDN_CYCLES(50), .PWM_PRESCALE(2),
    .MEAS_CNT_W(10)) led_dimming_control_i (.clk(clk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .active(active),
    .external_pwm_duty(ext_pwm), .enable_pin(enable_pin),
    .channel_on(channel_on), .dc_current_level(dc_level));
  initial forever #12.5 clk = ~clk;
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test;
    end
  end
  task automatic cmp(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic count_on(input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(negedge clk);
      if (channel_on === 6'h3f) c = c + 16'h0001;
    end
  endtask
  task automatic reset_values;
    logic [7:0] d;
    rd(8'h00, d);
    cmp(d, 8'hff);
    rd(8'h01, d);
    cmp(d, 8'h01);
    rd(8'h07, d);
    cmp(d, 8'hff);
    rd(8'h3c, d);
    cmp(d, 8'h00);
    cmp(dc_level, 8'hff);
  endtask
  task automatic ratio_default;
    logic [15:0] c;
    repeat (600) @(negedge clk);
    count_on(510, c);
    cmp(c, 16'h00fe);
    wr(8'h00, 8'h80);
    repeat (520) @(negedge clk);
    count_on(510, c);
    cmp(c, 16'h007e);
  endtask
  task automatic internal_steps;
    logic [15:0] c;
    logic [7:0] b [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
    wr(8'h01, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, b[i]);
      repeat (520) @(negedge clk);
      count_on(510, c);
      cmp(c, b[i] == 8'hff ? 16'h01fe : {7'h00, b[i], 1'b0});
    end
  endtask
  task automatic external_mode;
    logic [15:0] c;
    logic [3:0] h [3] = '{4'h0, 4'h5, 4'hf};
    wr(8'h01, 8'h03);
    for (int i = 0; i < 3; i++) begin
      high_cnt = h[i];
      repeat (40) @(negedge clk);
      count_on(160, c);
      cmp(c, {12'h000, h[i]} * 16'h000a);
    end
  endtask
  task automatic dc_level_change;
    logic [15:0] c;
    wr(8'h07, 8'hc8);
    cmp(dc_level, 8'hc8);
    wr(8'h07, 8'h00);
    repeat (4) @(negedge clk);
    count_on(32, c);
    cmp(c, 16'h0000);
    wr(8'h07, 8'hff);
  endtask
  task automatic shutdown;
    logic [15:0] c;
    enable_pin = 1'b0;
    repeat (40) @(negedge clk);
    cmp(active, 1'b1);
    for (int n = 0; n < 30 && active !== 1'b0; n++) @(negedge clk);
    cmp(active, 1'b0);
    count_on(16, c);
    cmp(c, 16'h0000);
    enable_pin = 1'b1;
    repeat (5) @(negedge clk);
    cmp(active, 1'b1);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    reset_values;
    ratio_default;
    internal_steps;
    external_mode;
    dc_level_change;
    shutdown;
    end_of_test;
  end
endmodule
`default_nettype wire
